/* File: candidate_screen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "des_search_defines.svh"

module candidate_screen (
  input  wire des_search_pkg::search_config_t cfg,
  input  wire logic                           block_select,
  input  wire logic                           hunt_running,
  input  wire logic [`BLK_W-1:0]              des_result,
  output logic                                reject
);

  localparam int HALF = `BLK_W / 2;

  logic [`BLK_W-1:0]  folded;
  logic [`BLK_W-1:0]  post;
  logic [`MASK_W-1:0] bad;

  // Left half is the upper word
  assign folded = cfg.half_fold_enable ?
                  {des_result[`BLK_W-1:HALF] ^ des_result[HALF-1:0], des_result[HALF-1:0]}
                  : des_result;

  // Fold first, then mask the first block or chain the second; the two never apply to one block
  assign post = !block_select ? (folded ^ cfg.output_xor_mask)
              : cfg.chain_xor_enable ? (folded ^ cfg.first_block)
              : folded;

  // Mask bit k covers bits 8k+7..8k, so 0x80 lands on left byte 0
  genvar k;
  generate
    for (k = 0; k < `MASK_W; k++) begin : g_byte
      assign bad[k] = !cfg.byte_ignore_mask[k] &&
                      !cfg.allowed_byte_table[post[k*8 +: 8]];
    end
  endgenerate

  assign reject = hunt_running && (|bad);

endmodule : candidate_screen

`default_nettype wire

/* File: des_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "des_search_defines.svh"

// ==========================================================
// Engine stand-in: result = block ^ key, so checks are predictable;
// alternates fast and slow answers to exercise both pacing limits
module des_engine_model (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire des_search_pkg::des_req_t des_req [`N_UNITS],
  input wire logic [`N_UNITS-1:0]      des_start,
  output logic [`N_UNITS-1:0]          des_done,
  output logic [`BLK_W-1:0]            des_result [`N_UNITS]
);
  logic [4:0]          cnt_r [`N_UNITS];
  logic [`N_UNITS-1:0] slow_r;
  logic [`BLK_W-1:0]   val_r [`N_UNITS];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      des_done <= '0;
      slow_r <= '0;
      for (int u = 0; u < `N_UNITS; u++) begin
        cnt_r[u] <= 5'h00;
        val_r[u] <= '0;
        des_result[u] <= '0;
      end
    end else begin
      for (int u = 0; u < `N_UNITS; u++) begin
        // Result lines toggle outside done so stale data is never trusted
        des_done[u]   <= !des_start[u] && (cnt_r[u] == 5'h01);
        des_result[u] <= (!des_start[u] && (cnt_r[u] == 5'h01)) ? val_r[u] : ~des_result[u];
        if (des_start[u]) begin
          cnt_r[u] <= slow_r[u] ? 5'h14 : 5'h02;
          slow_r[u] <= ~slow_r[u];
          val_r[u] <= des_req[u].block ^ {8'h00, des_req[u].key};
        end else if (cnt_r[u] == 5'h01) begin
          cnt_r[u] <= 5'h00;
        end else if (cnt_r[u] != 5'h00) begin
          cnt_r[u] <= cnt_r[u] - 5'h01;
        end
      end
    end
  end
endmodule : des_engine_model

`default_nettype wire

/* File: des_key_search_unit_checker.sv */
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "des_search_defines.svh"

module des_key_search_unit_checker (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`ADDR_W-1:0]       paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  output des_search_pkg::des_req_t      des_req [`N_UNITS],
  output logic      [`N_UNITS-1:0]      des_start,
  input  wire logic [`N_UNITS-1:0]      des_done,
  input  wire logic [`BLK_W-1:0]        des_result [`N_UNITS],
  output logic                          chip_halted
);

  // ========================================================================
  // Bus decode
  logic                     setup;
  logic                     wr_en;
  logic [3:0]               wi;
  logic                     common_hit;
  logic                     unit_hit;
  logic [4:0]               unit_idx;
  logic                     unit_ok;
  logic                     unit_hi;
  logic                     table_hit;
  logic [2:0]               table_wi;

  assign setup      = psel && !penable;
  assign wr_en      = psel && penable && pwrite;
  assign wi         = paddr[`WI_MSB:`WI_LSB];
  assign common_hit = (paddr[`COMMON_MSB:`COMMON_LSB] == `COMMON_PAGE)
                      && (paddr[1:0] == 2'h0);
  assign unit_hit   = (paddr[`PAGE_MSB:`PAGE_LSB] == `UNIT_PAGE)
                      && (paddr[1:0] == 2'h0);
  assign unit_idx   = paddr[`UNIT_IDX_MSB:`UNIT_IDX_LSB];
  assign unit_ok    = unit_hit && (unit_idx < 5'(`N_UNITS));
  assign unit_hi    = paddr[`UNIT_HI_BIT];
  assign table_hit  = common_hit && (wi <= `WI_TABLE_LAST);
  assign table_wi   = wi[`TABLE_WI_MSB:0];

  // Zero wait states: read data is taken at setup, so it is ready in access
  assign pready = 1'b1;

  // ========================================================================
  // Common configuration registers
  logic [`TABLE_W-1:0]  table_r;
  logic [`BLK_W-1:0]    xor_mask_r;
  logic [`BLK_W-1:0]    first_r;
  logic [`BLK_W-1:0]    second_r;
  logic [`MASK_W-1:0]   byte_mask_r;
  logic                 chain_r;
  logic                 fold_r;

  des_search_pkg::search_config_t cfg;

  assign cfg.allowed_byte_table = table_r;
  assign cfg.output_xor_mask    = xor_mask_r;
  assign cfg.first_block        = first_r;
  assign cfg.second_block       = second_r;
  assign cfg.byte_ignore_mask   = byte_mask_r;
  assign cfg.chain_xor_enable   = chain_r;
  assign cfg.half_fold_enable   = fold_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_r <= '0;
    end else if (wr_en && table_hit) begin
      table_r[table_wi*32 +: 32] <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xor_mask_r  <= '0;
      first_r     <= '0;
      second_r    <= '0;
      byte_mask_r <= '0;
      chain_r     <= 1'b0;
      fold_r      <= 1'b0;
    end else if (wr_en && common_hit) begin
      unique case (wi)
        `WI_XOR_LO:    xor_mask_r[31:0]  <= pwdata;
        `WI_XOR_HI:    xor_mask_r[63:32] <= pwdata;
        `WI_FIRST_LO:  first_r[31:0]     <= pwdata;
        `WI_FIRST_HI:  first_r[63:32]    <= pwdata;
        `WI_SECOND_LO: second_r[31:0]    <= pwdata;
        `WI_SECOND_HI: second_r[63:32]   <= pwdata;
        `WI_BYTE_MASK: byte_mask_r       <= pwdata[`MASK_W-1:0];
        `WI_CONFIG: begin
          chain_r <= pwdata[`CFG_CHAIN];
          fold_r  <= pwdata[`CFG_FOLD];
        end
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Search units
  logic [`KEY_W-1:0]   key_r   [`N_UNITS];
  logic [`N_UNITS-1:0] run_r;
  logic [`N_UNITS-1:0] sel_r;

  genvar u;
  generate
    for (u = 0; u < `N_UNITS; u++) begin : g_unit
      des_search_pkg::unit_state_t state_r;
      des_search_pkg::unit_state_t state_nxt;
      logic [`PACE_W-1:0] pace_r;
      logic               issue;
      logic               check;
      logic               reject;
      logic               hw_lo;
      logic               hw_hi;
      logic               advance;
      logic [`KEY_W-1:0]  key_nxt;
      logic               sel_nxt;
      logic               run_nxt;

      assign hw_lo = wr_en && unit_ok && (unit_idx == 5'(u)) && !unit_hi;
      assign hw_hi = wr_en && unit_ok && (unit_idx == 5'(u)) && unit_hi;

      // Pacing holds a trial to at least the nominal length even with a fast engine
      assign issue = (state_r == des_search_pkg::S_ISSUE) && (pace_r == '0);
      assign check = (state_r == des_search_pkg::S_WAIT) && des_done[u];

      candidate_screen u_screen (
        .cfg          (cfg),
        .block_select (sel_r[u]),
        .hunt_running (run_r[u]),
        .des_result   (des_result[u]),
        .reject       (reject)
      );

      // A halted unit keeps looping and holds its key for the host, one past the key that passed, as the halting check still advances it
      assign advance = check && (reject || (sel_r[u] && run_r[u]));

      assign key_nxt = hw_lo   ? {key_r[u][`KEY_W-1:`KEY_LO_W], pwdata}
                     : hw_hi   ? {pwdata[`KEY_HI_W-1:0], key_r[u][`KEY_LO_W-1:0]}
                     : advance ? key_r[u] + `KEY_W'(1)
                     : key_r[u];

      assign sel_nxt = hw_hi ? pwdata[`ST_SEL]
                     : check ? !reject
                     : sel_r[u];

      // Both blocks must pass in turn before the unit stops
      assign run_nxt = hw_hi ? pwdata[`ST_RUN]
                     : (check && !reject && sel_r[u]) ? 1'b0
                     : run_r[u];

      always_comb begin
        state_nxt = state_r;
        unique case (state_r)
          des_search_pkg::S_ISSUE: if (issue) state_nxt = des_search_pkg::S_WAIT;
          des_search_pkg::S_WAIT:  if (check) state_nxt = des_search_pkg::S_ISSUE;
          default:                 state_nxt = des_search_pkg::S_ISSUE;
        endcase
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          state_r  <= des_search_pkg::S_ISSUE;
          pace_r   <= '0;
          key_r[u] <= '0;
          run_r[u] <= 1'b0;
          sel_r[u] <= 1'b0;
        end else begin
          state_r  <= state_nxt;
          pace_r   <= issue ? `PACE_W'(`TRIAL_CYCLES - 1)
                    : (pace_r != '0) ? pace_r - `PACE_W'(1) : pace_r;
          key_r[u] <= key_nxt;
          run_r[u] <= run_nxt;
          sel_r[u] <= sel_nxt;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          des_start[u] <= 1'b0;
          des_req[u]   <= '0;
        end else begin
          des_start[u] <= issue;
          if (issue) begin
            des_req[u].key   <= key_r[u];
            des_req[u].block <= sel_r[u] ? second_r : first_r;
          end
        end
      end
    end
  endgenerate

  // ========================================================================
  // Read-back
  logic all_active;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [31:0] common_word;
  logic [31:0] unit_word;

  assign all_active = &run_r;

  always_comb begin
    common_word = '0;
    unique case (wi)
      `WI_XOR_LO:    common_word = xor_mask_r[31:0];
      `WI_XOR_HI:    common_word = xor_mask_r[63:32];
      `WI_FIRST_LO:  common_word = first_r[31:0];
      `WI_FIRST_HI:  common_word = first_r[63:32];
      `WI_SECOND_LO: common_word = second_r[31:0];
      `WI_SECOND_HI: common_word = second_r[63:32];
      `WI_BYTE_MASK: common_word = {24'h0, byte_mask_r};
      `WI_CONFIG: begin
        common_word[`CFG_CHAIN]      = chain_r;
        common_word[`CFG_FOLD]       = fold_r;
        common_word[`CFG_ALL_ACTIVE] = all_active;
      end
      default:       common_word = table_r[table_wi*32 +: 32];
    endcase
  end

  always_comb begin
    unit_word = '0;
    if (unit_ok) begin
      if (unit_hi) begin
        unit_word[`KEY_HI_W-1:0] = key_r[unit_idx][`KEY_W-1:`KEY_LO_W];
        unit_word[`ST_RUN]       = run_r[unit_idx];
        unit_word[`ST_SEL]       = sel_r[unit_idx];
      end else begin
        unit_word = key_r[unit_idx][`KEY_LO_W-1:0];
      end
    end
  end

  assign rd_ok   = common_hit || unit_ok;
  assign rd_word = common_hit ? common_word : unit_word;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0 : rd_word;
      pslverr <= !rd_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_halted <= 1'b0;
    end else begin
      chip_halted <= !all_active;
    end
  end

endmodule : des_key_search_unit_checker

`default_nettype wire

/* File: des_key_search_unit_checker_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "des_search_defines.svh"

module des_key_search_unit_checker_tb;
  logic                     pclk = 1'b0;
  logic                     presetn;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [`ADDR_W-1:0]       paddr = '0;
  logic [31:0]              pwdata = '0;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  des_search_pkg::des_req_t des_req [`N_UNITS];
  logic [`N_UNITS-1:0]      des_start;
  logic [`N_UNITS-1:0]      des_done;
  logic [`BLK_W-1:0]        des_result [`N_UNITS];
  logic                     chip_halted;
  logic [31:0]              rd;
  logic                     err;
  int                       n_mismatch = 0;
  int                       samples_checked = 0;
  int                       cycles = 0;
  logic [11:0]              rst_addr [4] = '{12'h000, 12'h020, 12'h03C, 12'h100};

  always #20 pclk = ~pclk;

  des_key_search_unit_checker dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .des_req(des_req), .des_start(des_start),
    .des_done(des_done), .des_result(des_result), .chip_halted(chip_halted));
  des_engine_model eng (.pclk(pclk), .presetn(presetn), .des_req(des_req),
    .des_start(des_start), .des_done(des_done), .des_result(des_result));

  // ==========================================================
  // Bus access and checking
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic setup(input logic [31:0] tbl, xm, b0, b1, input logic [7:0] msk,
                       input logic [1:0] cfg);
    apb(1'b1, 12'h000, tbl);
    apb(1'b1, 12'h020, xm);
    apb(1'b1, 12'h028, b0);
    apb(1'b1, 12'h030, b1);
    apb(1'b1, 12'h038, {24'h0, msk});
    apb(1'b1, 12'h03C, {30'h0, cfg});
  endtask : setup

  // Stop, load the key, let any trial in flight drain, then run
  task automatic start_unit(input logic [23:0] hi, input logic [31:0] lo);
    apb(1'b1, 12'h104, {8'h00, hi});
    apb(1'b1, 12'h100, lo);
    repeat (50) @(posedge pclk);
    apb(1'b1, 12'h104, {7'h00, 1'b1, hi});
  endtask : start_unit

  task automatic expect_halt(input logic [23:0] hi, input logic [31:0] lo);
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h104, 32'h0);
      n++;
    end while (rd[24] !== 1'b0 && n < 100);
    chk(rd, {6'h00, 2'h2, hi});
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, lo);
  endtask : expect_halt

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_addr[i]) begin
      apb(1'b0, rst_addr[i], 32'h0);
      chk(rd, 32'h0);
    end
    chk({31'h0, chip_halted}, 32'h1);
    apb(1'b1, 12'h038, 32'hFFFF_FFFF);
    apb(1'b0, 12'h038, 32'h0);
    chk(rd, 32'h0000_00FF);
    apb(1'b1, 12'h1B8, 32'h1234_5678);
    apb(1'b0, 12'h1B8, 32'h0);
    chk(rd, 32'h1234_5678);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Only value 5 allowed, only right byte 3 examined
    setup(32'h20, 32'h0, 32'h0, 32'h0, 8'hFE, 2'h0);
    start_unit(24'h0, 32'h3);
    expect_halt(24'h0, 32'h6);
    // Second block passes only if chained and left unmasked
    setup(32'h20, 32'h1, 32'h1, 32'h1, 8'hFE, 2'h1);
    start_unit(24'h0, 32'h3);
    expect_halt(24'h0, 32'h6);
    // Left half only, zero after folding right onto left
    setup(32'h1, 32'h0, 32'h0, 32'h0, 8'h0F, 2'h2);
    start_unit(24'h3, 32'h1);
    expect_halt(24'h3, 32'h4);
    end_sim();
  end
endmodule : des_key_search_unit_checker_tb

bind des_key_search_unit_checker des_search_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .des_req(des_req),
  .des_start(des_start), .des_done(des_done), .des_result(des_result),
  .chip_halted(chip_halted));

`default_nettype wire

/* File: des_search_defines.svh */
`ifndef DES_SEARCH_DEFINES_SVH
`define DES_SEARCH_DEFINES_SVH

// ==========================================================================
// Sizes
`define N_UNITS        24
`define KEY_W          56
`define BLK_W          64
`define TABLE_W        256
`define MASK_W         8
`define ADDR_W         12
`define TRIAL_CYCLES   16
`define PACE_W         4

// ==========================================================================
// Common register word indices (byte address = index * 4)
`define WI_TABLE_LAST  4'h7
`define WI_XOR_LO      4'h8
`define WI_XOR_HI      4'h9
`define WI_FIRST_LO    4'hA
`define WI_FIRST_HI    4'hB
`define WI_SECOND_LO   4'hC
`define WI_SECOND_HI   4'hD
`define WI_BYTE_MASK   4'hE
`define WI_CONFIG      4'hF

// ==========================================================================
// Address decode fields
`define WI_MSB         5
`define WI_LSB         2
`define COMMON_MSB     11
`define COMMON_LSB     6
`define COMMON_PAGE    6'h00
`define PAGE_MSB       11
`define PAGE_LSB       8
`define UNIT_PAGE      4'h1
`define UNIT_IDX_MSB   7
`define UNIT_IDX_LSB   3
`define UNIT_HI_BIT    2
`define TABLE_WI_MSB   2

// ==========================================================================
// Field positions
`define CFG_CHAIN      0
`define CFG_FOLD       1
`define CFG_ALL_ACTIVE 2
`define KEY_LO_W       32
`define KEY_HI_W       24
`define ST_RUN         24
`define ST_SEL         25

`endif

/* File: des_search_pkg.sv */
`include "des_search_defines.svh"

package des_search_pkg;

  // Block and key handed to one unit's decryption engine
  typedef struct packed {
    logic [`KEY_W-1:0] key;
    logic [`BLK_W-1:0] block;
  } des_req_t;

  // Settings shared by all search units
  typedef struct packed {
    logic [`TABLE_W-1:0] allowed_byte_table;
    logic [`BLK_W-1:0]   output_xor_mask;
    logic [`BLK_W-1:0]   first_block;
    logic [`BLK_W-1:0]   second_block;
    logic [`MASK_W-1:0]  byte_ignore_mask;
    logic                chain_xor_enable;
    logic                half_fold_enable;
  } search_config_t;

  typedef enum logic [1:0] {
    S_ISSUE = 2'b01,
    S_WAIT  = 2'b10
  } unit_state_t;

endpackage : des_search_pkg

/* File: des_search_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "des_search_defines.svh"

module des_search_props (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [`ADDR_W-1:0]       paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire des_search_pkg::des_req_t des_req [`N_UNITS],
  input wire logic [`N_UNITS-1:0]      des_start,
  input wire logic [`N_UNITS-1:0]      des_done,
  input wire logic [`BLK_W-1:0]        des_result [`N_UNITS],
  input wire logic                     chip_halted
);
  // ==========================================================
  // Unit 0 stands in for all units; they share one pacing scheme
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_pulse: assert property (des_start[0] |=> !des_start[0])
    else $error("engine start longer than one cycle");
  a_trial_pace: assert property (des_start[0] |=> (!des_start[0])[*8] ##1 (!des_start[0])[*7])
    else $error("trials closer than sixteen cycles");
  a_restart_bound: assert property (des_done[0] |-> ##[2:16] des_start[0])
    else $error("next trial not started in time");
  a_done_gap: assert property (des_done[0] |=> !des_start[0])
    else $error("trial started before the update");
  a_req_hold: assert property ($changed(des_req[0]) |-> des_start[0])
    else $error("engine request moved without a start");
  a_common_ok: assert property (psel && !penable && paddr < 12'h040 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("common register refused");
  a_unit_ok: assert property (psel && !penable && paddr[11:8] == 4'h1 && paddr[7:6] != 2'h3 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("unit register refused");
  a_gap_refused: assert property (psel && !penable && paddr[11:6] inside {6'h01, 6'h02, 6'h03} |=> pslverr && prdata == 32'h0)
    else $error("unmapped address accepted");
endmodule : des_search_props

`default_nettype wire
